// [hdl/sccl_pkg.sv]
package sccl_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int CFG_BITS_DEF = 64;
  localparam int REF_CLK_MHZ = 50;
  localparam int DEFAULT_PROG_NS = 1000;
  // least time rounds up to whole reference cycles
  localparam int DEFAULT_PROG_CYC = (DEFAULT_PROG_NS * REF_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic DONE_OUT_RST = 1'b1;
  localparam logic ENABLE_B_RST = 1'b1;
  localparam logic SER_OUT_RST = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CAPTURE = 4'h1,
    ST_DEFAULT = 4'h2,
    ST_SERIAL  = 4'h4,
    ST_DONE    = 4'h8
  } sccl_state_t;

  // link-side levels carried into the reference domain
  typedef struct packed {
    logic done;
    logic enable_b;
  } sccl_link_t;

endpackage : sccl_pkg

// [hdl/sccl_shift_reg.sv]
`timescale 1ns/1ps
module sccl_shift_reg #(
  parameter int WIDTH = 64
) (
  input wire logic i_clk, // serial clock
  input wire logic i_rst_b, // synchronised reset, active low
  input wire logic i_shift, // advance one place
  input wire logic i_bit, // bit entering at position 0
  output logic [WIDTH-1:0] o_word // setup register contents
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 2) begin : g_chk
    $error("sccl_shift_reg needs WIDTH of two or more");
  end

  // ----------------------------------------------------------------
  // setup register
  // ----------------------------------------------------------------
  // one place per qualified edge, newest bit in position 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_word <= '0;
    end else if (i_shift) begin
      o_word <= {o_word[WIDTH-2:0], i_bit};
    end
  end

  shift_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_shift |=> o_word[WIDTH-1:1] == $past(o_word[WIDTH-2:0]))
    else $error("setup register did not advance one place");

endmodule : sccl_shift_reg

// [hdl/sccl_top.sv]
`timescale 1ns/1ps
module sccl_top #(
  parameter int CFG_BITS = sccl_pkg::CFG_BITS_DEF,
  parameter int DEFAULT_CYC = sccl_pkg::DEFAULT_PROG_CYC,
  parameter logic [CFG_BITS-1:0] DEFAULT_SETUP = '0
) (
  input wire logic i_ref_clk, // core clock, 50 MHz
  input wire logic i_rst_b, // master reset, active low
  input wire logic i_ser_clk, // serial configuration clock
  input wire logic i_serial_mode, // strap: serial programming chosen
  input wire logic i_cfg_load_enable_in_b, // serial load enable, active low
  input wire logic i_ser_data, // serial data in
  input wire logic i_read_queue_select_strobe, // raw read queue select
  output logic o_ser_data, // serial data out to next device
  output logic o_cfg_done_enable_out_b, // completion output, active low
  output logic o_ops_permitted, // normal queue operations allowed
  output logic o_read_queue_select_strobe, // qualified read queue select
  output logic o_cfg_valid, // setup word captured
  output logic [CFG_BITS-1:0] o_cfg_setup // configuration in use
);

  localparam int CNT_W = $clog2(CFG_BITS);
  localparam int DCNT_W = $clog2(DEFAULT_CYC + 1);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CFG_BITS < 2) begin : g_chk_bits
    $error("CFG_BITS must be two or more");
  end
  if (DEFAULT_CYC < 1) begin : g_chk_dflt
    $error("DEFAULT_CYC must be one or more");
  end

  // ----------------------------------------------------------------
  // reference domain: reset release and strap sampling
  // ----------------------------------------------------------------
  logic rst_meta_ff, rst_sync_ff;
  logic mode_meta_ff, mode_sync_ff;
  logic rq_meta_ff, rq_sync_ff;
  sccl_pkg::sccl_link_t lk_meta_ff, lk_sync_ff;
  sccl_pkg::sccl_state_t state_ff, nxt_state;
  logic serial_mode_ff, prog_done_ff;
  logic [DCNT_W-1:0] dflt_cnt_ff;
  // link-domain items read by the crossings below, declared ahead of use
  logic ser_done_ff, shift_en, pass_en;
  logic [CFG_BITS-1:0] setup_word_lk;

  // reset released through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // pin synchronisers run through reset so the strap is valid at release
  always_ff @(posedge i_ref_clk) begin
    mode_meta_ff <= i_serial_mode;
    mode_sync_ff <= mode_meta_ff;
    rq_meta_ff <= i_read_queue_select_strobe;
    rq_sync_ff <= rq_meta_ff;
  end

  // link status levels crossing into the reference domain
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lk_meta_ff <= '{done: 1'b0, enable_b: sccl_pkg::ENABLE_B_RST};
      lk_sync_ff <= '{done: 1'b0, enable_b: sccl_pkg::ENABLE_B_RST};
    end else begin
      lk_meta_ff <= '{done: ser_done_ff, enable_b: i_cfg_load_enable_in_b};
      lk_sync_ff <= lk_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // reference domain: programming sequence
  // ----------------------------------------------------------------
  // mode is decided once, in the first cycle after release
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sccl_pkg::ST_CAPTURE: begin
        nxt_state = mode_sync_ff ? sccl_pkg::ST_SERIAL : sccl_pkg::ST_DEFAULT;
      end
      sccl_pkg::ST_DEFAULT: begin
        if (dflt_cnt_ff == DCNT_W'(DEFAULT_CYC - 1)) begin
          nxt_state = sccl_pkg::ST_DONE;
        end
      end
      sccl_pkg::ST_SERIAL: begin
        if (lk_sync_ff.done) begin
          nxt_state = sccl_pkg::ST_DONE;
        end
      end
      sccl_pkg::ST_DONE: begin
        nxt_state = sccl_pkg::ST_DONE;
      end
      default: begin
        nxt_state = sccl_pkg::ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= sccl_pkg::ST_CAPTURE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // strap captured by a clocked process, never by the reset itself
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      serial_mode_ff <= 1'b0;
    end else if (state_ff == sccl_pkg::ST_CAPTURE) begin
      serial_mode_ff <= mode_sync_ff;
    end
  end

  // default programming time
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dflt_cnt_ff <= '0;
    end else if (state_ff == sccl_pkg::ST_DEFAULT) begin
      dflt_cnt_ff <= dflt_cnt_ff + 1'b1;
    end
  end

  // registered done flag, safe to pass to the link domain
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      prog_done_ff <= 1'b0;
    end else begin
      prog_done_ff <= (nxt_state == sccl_pkg::ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // reference domain: outputs
  // ----------------------------------------------------------------
  // completion stays high until done, then mirrors the enable
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_cfg_done_enable_out_b <= sccl_pkg::DONE_OUT_RST;
    end else begin
      o_cfg_done_enable_out_b <= ~(prog_done_ff & ~lk_sync_ff.enable_b);
    end
  end

  // first low completion opens normal operation for good
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_ops_permitted <= 1'b0;
    end else if (!o_cfg_done_enable_out_b) begin
      o_ops_permitted <= 1'b1;
    end
  end

  // a select before completion is dropped, not queued
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_read_queue_select_strobe <= 1'b0;
    end else begin
      o_read_queue_select_strobe <= rq_sync_ff & o_ops_permitted;
    end
  end

  // word is frozen once the link reports done, so a plain capture is safe
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_cfg_setup <= '0;
      o_cfg_valid <= 1'b0;
    end else if (!o_cfg_valid && state_ff == sccl_pkg::ST_SERIAL && lk_sync_ff.done) begin
      o_cfg_setup <= setup_word_lk;
      o_cfg_valid <= 1'b1;
    end else if (!o_cfg_valid && state_ff == sccl_pkg::ST_DEFAULT && nxt_state == sccl_pkg::ST_DONE) begin
      o_cfg_setup <= DEFAULT_SETUP;
      o_cfg_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // link domain: reset and crossings
  // ----------------------------------------------------------------
  logic lrst_meta_ff, lrst_sync_ff;
  logic lmode_meta_ff, lmode_sync_ff;
  logic ldone_meta_ff, ldone_sync_ff;
  logic [CNT_W-1:0] bit_cnt_ff;

  always_ff @(posedge i_ser_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lrst_meta_ff <= 1'b0;
      lrst_sync_ff <= 1'b0;
    end else begin
      lrst_meta_ff <= 1'b1;
      lrst_sync_ff <= lrst_meta_ff;
    end
  end

  // serial clock may stop, so these settle only on its own edges
  always_ff @(posedge i_ser_clk or negedge lrst_sync_ff) begin
    if (!lrst_sync_ff) begin
      lmode_meta_ff <= 1'b0;
      lmode_sync_ff <= 1'b0;
      ldone_meta_ff <= 1'b0;
      ldone_sync_ff <= 1'b0;
    end else begin
      lmode_meta_ff <= serial_mode_ff;
      lmode_sync_ff <= lmode_meta_ff;
      ldone_meta_ff <= prog_done_ff;
      ldone_sync_ff <= ldone_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // link domain: loading and pass-through
  // ----------------------------------------------------------------
  assign shift_en = lmode_sync_ff & ~i_cfg_load_enable_in_b & ~ser_done_ff;
  assign pass_en = (ser_done_ff | ldone_sync_ff) & ~i_cfg_load_enable_in_b;

  sccl_shift_reg #(
    .WIDTH(CFG_BITS)
  ) u_setup (
    .i_clk(i_ser_clk),
    .i_rst_b(lrst_sync_ff),
    .i_shift(shift_en),
    .i_bit(i_ser_data),
    .o_word(setup_word_lk)
  );

  // loading ends after exactly CFG_BITS qualified edges
  always_ff @(posedge i_ser_clk or negedge lrst_sync_ff) begin
    if (!lrst_sync_ff) begin
      bit_cnt_ff <= '0;
      ser_done_ff <= 1'b0;
    end else if (shift_en) begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      if (bit_cnt_ff == CNT_W'(CFG_BITS - 1)) begin
        ser_done_ff <= 1'b1;
      end
    end
  end

  // one serial-clock stage of retiming keeps the output a flop
  always_ff @(posedge i_ser_clk or negedge lrst_sync_ff) begin
    if (!lrst_sync_ff) begin
      o_ser_data <= sccl_pkg::SER_OUT_RST;
    end else begin
      o_ser_data <= pass_en ? i_ser_data : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  bit_capture_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    shift_en |=> setup_word_lk[0] == $past(i_ser_data))
    else $error("serial bit not captured");
  enable_high_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    i_cfg_load_enable_in_b |=> $stable(setup_word_lk) && $stable(bit_cnt_ff))
    else $error("loading while enable high");
  mode_gate_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    !lmode_sync_ff |=> $stable(setup_word_lk))
    else $error("shift outside serial mode");
  done_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    !prog_done_ff |-> o_cfg_done_enable_out_b)
    else $error("completion low before programming done");
  follow_low_a: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    prog_done_ff && !lk_sync_ff.enable_b |=> !o_cfg_done_enable_out_b)
    else $error("completion did not follow enable low");
  follow_high_a: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    lk_sync_ff.enable_b |=> o_cfg_done_enable_out_b)
    else $error("completion did not follow enable high");
  ops_open_a: assert property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    $fell(o_cfg_done_enable_out_b) |=> o_ops_permitted ##1 o_ops_permitted)
    else $error("operations not permitted after completion");
  pass_through_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    pass_en |=> o_ser_data == $past(i_ser_data))
    else $error("serial data not forwarded");
  pass_block_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    !pass_en |=> !o_ser_data)
    else $error("serial data forwarded too early");
  bit_count_a: assert property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    shift_en && bit_cnt_ff == CNT_W'(CFG_BITS - 1) |=> ser_done_ff && !shift_en)
    else $error("loading did not end at the bit count");

  serial_done_c: cover property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    state_ff == sccl_pkg::ST_SERIAL ##1 state_ff == sccl_pkg::ST_DONE);
  default_done_c: cover property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    state_ff == sccl_pkg::ST_DEFAULT ##1 state_ff == sccl_pkg::ST_DONE);
  forward_c: cover property (@(posedge i_ser_clk) disable iff (!lrst_sync_ff)
    pass_en && i_ser_data);
  select_c: cover property (@(posedge i_ref_clk) disable iff (!rst_sync_ff)
    o_read_queue_select_strobe);

endmodule : sccl_top

// [verif/sccl_host_model.sv]
`timescale 1ns/1ps
module sccl_host_model (
  input wire logic i_clk_free, // free-running 64 ns source
  input wire logic i_done_b, // completion of last device, active low
  output logic o_ser_clk, // gated serial clock
  output logic o_en_b, // load enable of first device, active low
  output logic o_data // serial data
);
  logic run_ff = 1'b0;
  logic busy_ff = 1'b0;

  // ----------------------------------------------------------------
  // clock and idle line
  // ----------------------------------------------------------------
  // clock stands still between frames; run only moves while source is low
  assign o_ser_clk = i_clk_free & run_ff;
  initial begin
    o_en_b = 1'b1;
    o_data = 1'b0;
  end
  // idle data keeps changing so a stale bit never looks valid
  always @(posedge i_clk_free) begin
    if (!busy_ff) begin
      o_data <= #8 ~o_data;
    end
  end

  // ----------------------------------------------------------------
  // host actions
  // ----------------------------------------------------------------
  // a few running edges, for reset sync or to carry an enable level
  task automatic tick(input int n);
    @(negedge i_clk_free);
    run_ff = 1'b1;
    repeat (n) @(negedge i_clk_free);
    run_ff = 1'b0;
  endtask : tick

  // first device enable comes from the host, later ones from the chain
  task automatic set_en(input logic v);
    @(negedge i_clk_free);
    o_en_b = v;
    tick(4);
  endtask : set_en

  // one bit on one rising edge, enable low around it
  task automatic send_bit(input logic b);
    @(negedge i_clk_free);
    busy_ff = 1'b1;
    run_ff = 1'b1;
    o_en_b = 1'b0;
    o_data = b;
    @(negedge i_clk_free);
    run_ff = 1'b0;
    busy_ff = 1'b0;
  endtask : send_bit

  // msb first, so the first bit ends at the top of the setup word
  task automatic send_word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      send_bit(w[i]);
    end
  endtask : send_word

  // end of configuration is seen on the last completion output
  task automatic wait_done(input int n, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++) begin
      #20;
      if (i_done_b === 1'b0) begin
        ok = 1'b1;
      end
    end
  endtask : wait_done
endmodule : sccl_host_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int CB = 8;
  localparam logic [CB-1:0] DEF_WORD = 8'h3c;
  localparam logic [CB-1:0] SER_WORD = 8'ha5;
  logic i_ref_clk;
  logic clk_free;
  logic i_rst_b;
  logic i_serial_mode;
  logic i_read_queue_select_strobe;
  logic ser_clk, en_b, ser_data, ser_out, done_b, ops_ok, rq_out, cfg_valid;
  logic [CB-1:0] setup;
  logic [3:0] pat = 4'h6;
  int failures = 0;
  int checks_done = 0;

  // ----------------------------------------------------------------
  // clocks and instances
  // ----------------------------------------------------------------
  always #10 i_ref_clk = ~i_ref_clk;
  // link source offset so its edges never line up with the core clock
  initial begin
    clk_free = 1'b0;
    #7;
    forever #32 clk_free = ~clk_free;
  end
  sccl_host_model i_host (
    .i_clk_free(clk_free), .i_done_b(done_b), .o_ser_clk(ser_clk),
    .o_en_b(en_b), .o_data(ser_data));
  sccl_top #(.CFG_BITS(CB), .DEFAULT_CYC(4), .DEFAULT_SETUP(DEF_WORD)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ser_clk(ser_clk),
    .i_serial_mode(i_serial_mode), .i_cfg_load_enable_in_b(en_b),
    .i_ser_data(ser_data), .i_read_queue_select_strobe(i_read_queue_select_strobe),
    .o_ser_data(ser_out), .o_cfg_done_enable_out_b(done_b), .o_ops_permitted(ops_ok),
    .o_read_queue_select_strobe(rq_out), .o_cfg_valid(cfg_valid), .o_cfg_setup(setup));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [CB-1:0] got, input logic [CB-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // link clock ticks through reset so the link side leaves it too
  task automatic do_reset(input logic mode);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    i_serial_mode <= mode;
    fork
      i_host.tick(12);
      begin
        repeat (5) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
      end
    join
  endtask : do_reset

  // strobe held four cycles, output watched over the whole span
  task automatic strobe(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge i_ref_clk);
      i_read_queue_select_strobe <= (i < 4);
      #1;
      if (rq_out === 1'b1) begin
        seen = 1'b1;
      end
    end
    chk(seen, exp);
  endtask : strobe

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_serial();
    logic ok;
    do_reset(1'b1);
    strobe(1'b0);
    chk(ops_ok, 1'b0);
    for (int i = 7; i >= 1; i--) begin
      i_host.send_bit(SER_WORD[i]);
    end
    i_host.set_en(1'b1);
    chk(done_b, 1'b1);
    i_host.send_bit(1'b1);
    i_host.wait_done(40, ok);
    chk(ok, 1'b1);
    chk(setup, 8'ha5);
    chk(setup, 8'ha5);
    chk(cfg_valid, 1'b1);
    repeat (3) @(posedge i_ref_clk);
    chk(ops_ok, 1'b1);
    strobe(1'b1);
    for (int i = 0; i < 4; i++) begin
      i_host.send_bit(pat[i]);
      chk(ser_out, pat[i]);
    end
    chk(setup, 8'ha5);
    i_host.set_en(1'b1);
    repeat (4) @(posedge i_ref_clk);
    chk(done_b, 1'b1);
    chk(ser_out, 1'b0);
    i_host.set_en(1'b0);
    repeat (4) @(posedge i_ref_clk);
    chk(done_b, 1'b0);
  endtask : test_serial

  // default mode: setup register stays empty, data is forwarded, preset word is used
  task automatic test_default();
    logic ok;
    i_host.set_en(1'b1);
    do_reset(1'b0);
    repeat (20) @(posedge i_ref_clk);
    chk(done_b, 1'b1);
    i_host.set_en(1'b0);
    i_host.wait_done(40, ok);
    chk(ok, 1'b1);
    chk(setup, DEF_WORD);
    i_host.send_word(8'ha5);
    chk(ser_out, 1'b1);
    repeat (6) @(posedge i_ref_clk);
    chk(setup, DEF_WORD);
    chk(i_dut.setup_word_lk, 8'h00);
  endtask : test_default

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    i_ref_clk = 1'b0;
    i_rst_b = 1'b0;
    i_serial_mode = 1'b1;
    i_read_queue_select_strobe = 1'b0;
    test_serial();
    test_default();
    end_sim();
  end
  // both scenarios need well under 20 us; allow generous margin
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule : tb
